/* common/arc_prot_pkg.sv */
// Constants and types shared by the arc trip/block and common-signal logic.
// How it works
// - Blocking input sampled at each program-cycle start.
// - Unblocked pick-up rise sets zone trip.
// - Blocked pick-up rise sets blocked, nothing more.
// - Blocking comes only from dedicated input.
// - Condition word: trip and blocked per zone.
// - Sensor status word with eighteen sensor flags.
// - Every flag change emits event; zone trip rises add records.
// - Per-event selection of ON, OFF or both.
// - Events carry time stamp of occurrence.
// - Arc event counter, software resettable.
// - Twelve newest records kept, oldest overwritten.
// - Record: time, event, currents, sensors, group.
// - Common outputs OR all protection starts, trips.
// - Extra assigned inputs ORed into common outputs.
// - Force Start/Trip only while forcing enabled; Normal forces nothing.
// - Common condition is exactly one of three.
// - Common-signal function: block masks only zone pick-ups in start.
// - Common start/trip rise and fall give events.
// - Common start and trip event counter, resettable.
// - Zone trips only if enabled with source.
package arc_prot_pkg;

	localparam int NZONE     = 4;
	localparam int NCH       = 4;
	localparam int NFLAG     = 26;
	localparam int SENSOR_W  = 18;
	localparam int TS_W      = 48;
	localparam int CUR_W     = 16;
	localparam int GRP_W     = 3;
	localparam int EVT_W     = 6;
	localparam int CNT_W     = 16;
	localparam int ADDR_W    = 8;
	localparam int REC_DEPTH = 12;
	localparam int REC_IDX_W = 4;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] REG_FORCE     = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ZONE_CFG0 = 8'h08;
	localparam logic [ADDR_W-1:0] REG_ON_SEL    = 8'h18;
	localparam logic [ADDR_W-1:0] REG_OFF_SEL   = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_GEN_SEL   = 8'h20;
	localparam logic [ADDR_W-1:0] REG_ARC_COND  = 8'h24;
	localparam logic [ADDR_W-1:0] REG_SENSOR    = 8'h28;
	localparam logic [ADDR_W-1:0] REG_GEN_COND  = 8'h2c;
	localparam logic [ADDR_W-1:0] REG_ARC_CNT   = 8'h30;
	localparam logic [ADDR_W-1:0] REG_GEN_CNT   = 8'h34;
	localparam logic [ADDR_W-1:0] REG_REC_SEL   = 8'h38;
	localparam logic [ADDR_W-1:0] REG_REC_CNT   = 8'h3c;
	localparam logic [ADDR_W-1:0] REG_REC_TLO   = 8'h40;
	localparam logic [ADDR_W-1:0] REG_REC_THI   = 8'h44;
	localparam logic [ADDR_W-1:0] REG_REC_EVT   = 8'h48;
	localparam logic [ADDR_W-1:0] REG_REC_IAB   = 8'h4c;
	localparam logic [ADDR_W-1:0] REG_REC_IC0   = 8'h50;
	localparam int                ZONE_STRIDE   = 4;

	// Control register bits, write one to clear a counter.
	localparam int CTL_ARC_CLR = 0;
	localparam int CTL_GEN_CLR = 1;

	// Zone configuration fields.
	localparam int ZC_EN    = 0;
	localparam int ZC_PH    = 1;
	localparam int ZC_RES   = 2;
	localparam int ZC_LIGHT = 3;
	localparam int ZC_PRESS = 7;
	localparam int ZC_DI    = 11;
	localparam int ZC_W     = 13;

	// Flag positions in the arc event vector.
	localparam int F_TRIP   = 0;
	localparam int F_BLK    = 4;
	localparam int F_SENSOR = 8;
	localparam int F_PHBLK  = 8;
	localparam int F_PHST   = 9;
	localparam int F_RESBLK = 10;
	localparam int F_RESST  = 11;
	localparam int F_LIGHT  = 12;
	localparam int F_PRESS  = 16;
	localparam int F_DI     = 20;
	localparam int F_SFLT   = 21;
	localparam int F_IOFLT  = 25;

	// Common event selection fields and record word fields.
	localparam int GS_ON    = 0;
	localparam int GS_OFF   = 2;
	localparam int RE_EVT   = 0;
	localparam int RE_SENS  = 8;
	localparam int RE_GRP   = 16;
	localparam int TLO_W    = 32;

	// Reset values.
	localparam logic [NFLAG-1:0] SEL_RST     = 26'h3ff_ffff;
	localparam logic [3:0]       GEN_SEL_RST = 4'hf;

	typedef enum logic [1:0] {
		DI_OFF      = 2'h0,
		DI_LIGHT_IN = 2'h1,
		DI_CURR_IN  = 2'h2
	} di_mode_t;

	typedef enum logic [1:0] {
		FORCE_NORMAL = 2'h0,
		FORCE_START  = 2'h1,
		FORCE_TRIP   = 2'h2
	} force_t;

	typedef enum logic [2:0] {
		COND_NORMAL = 3'h1,
		COND_START  = 3'h2,
		COND_TRIP   = 3'h4
	} gen_cond_t;

	typedef struct packed {
		logic [TS_W-1:0]  ts;
		logic [EVT_W-1:0] evt;
		logic [CUR_W-1:0] ia;
		logic [CUR_W-1:0] ib;
		logic [CUR_W-1:0] ic;
		logic [CUR_W-1:0] i0;
		logic [NCH-1:0]   sens;
		logic [GRP_W-1:0] grp;
	} rec_t;

endpackage

/* verif/arc_field_model.sv */
// Far-side model: pick-up elements and blocking matrix for one cycle.
module arc_field_model
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_go,
	input  wire logic       i_blk,
	input  wire logic [3:0] i_lit,
	output logic            o_start,
	output logic            o_block,
	output logic      [3:0] o_light
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outputs are quiet until the first cycle is requested.
	initial {o_start, o_block, o_light} = 6'h00;
	// block with start
	// Block and sensors move with the start pulse, well ahead of any delay.
	always @(posedge i_ref_clk)
	begin
		o_start <= i_go;
		if (i_go)
			{o_block, o_light} <= {i_blk, i_lit};
	end
endmodule

/* verif/arc_trip_block_monitor.sv */
// Checker watching the arc trip/block and common-signal ports.
module arc_trip_block_monitor
#(
	parameter int NPROT = 8
)
(
	input wire logic             i_ref_clk, i_reset_n, i_hsel, i_hwrite,
	input wire logic             i_hready, o_hreadyout, i_cycle_start,
	input wire logic             i_block, i_common_start_in, i_force_enable,
	input wire logic             i_common_trip_in, o_common_trip, o_evt_valid,
	input wire logic             o_common_start,
	input wire logic [1:0]       i_htrans,
	input wire logic [2:0]       o_common_cond,
	input wire logic [3:0]       o_zone_trip_flag, o_zone_blocked_flag,
	input wire logic [47:0]      i_time_ms, o_evt_time,
	input wire logic [NPROT-1:0] i_prot_start, i_prot_trip
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	// A read data phase waits exactly one cycle.
	a_read_wait: assert property (i_hsel && i_htrans[1] && i_hready &&
		!i_hwrite |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait");
	a_trip_free: assert property (
		|(o_zone_trip_flag & ~$past(o_zone_trip_flag)) |-> !$past(i_block, 2))
		else $error("trip raised while block sampled");
	a_block_only: assert property (
		|(o_zone_blocked_flag & ~$past(o_zone_blocked_flag)) |->
		$past(i_block, 2)) else $error("blocked raised without block");
	a_zone_excl: assert property (
		(o_zone_trip_flag & o_zone_blocked_flag) == 4'h0)
		else $error("zone both tripped and blocked");
	a_cond_onehot: assert property (
		$onehot(o_common_cond) && o_common_trip == o_common_cond[2])
		else $error("common condition not one state");
	a_trip_or: assert property (
		i_cycle_start && !i_force_enable && (|i_prot_trip || i_common_trip_in)
		|-> ##2 o_common_trip) else $error("common trip missing");
	a_start_or: assert property (
		i_cycle_start && !i_force_enable && (|i_prot_start || i_common_start_in)
		|-> ##2 o_common_start) else $error("common start missing");
	a_evt_stamp: assert property (
		o_evt_valid |-> $past(i_cycle_start, 2) && o_evt_time ==
		$past(i_time_ms, 2)) else $error("event stamp wrong");
	a_flag_steady: assert property (
		!$past(i_cycle_start, 2) |-> $stable(o_zone_trip_flag) &&
		$stable(o_zone_blocked_flag)) else $error("flag moved off boundary");
	c_trip: cover property ($rose(o_zone_trip_flag[0]));
	c_block: cover property ($rose(o_zone_blocked_flag[0]));
	c_force: cover property (o_common_cond == 3'h2);
endmodule

bind arc_trip_block arc_trip_block_monitor #(.NPROT(NPROT))
	i_arc_trip_block_monitor (.*);

/* verif/arc_trip_block_tb.sv */
// Self-checking bench for the arc trip/block and common-signal block.
module arc_trip_block_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_ref_clk = 0, i_reset_n = 0, w = 0, go = 0, blk = 0;
	logic        xs = 0, xt = 0, fen = 0, cs, bl, hr, hp, st, tr;
	logic        ns, nt, es = 0, et = 0;
	logic [1:0]  ht = 0, ge, gf;
	logic [2:0]  cond;
	logic [3:0]  lit = 0, lt, zt, zb;
	logic [7:0]  ps = 0, pt = 0;
	logic [17:0] ss;
	logic [31:0] ha = 0, hd = 0, hrd, rdata, tm = 0, ex;
	logic [95:0] misc = 0;
	integer      seed = 32'hf76a_96ef;
	int          num_errors = 0, n_tests = 0, gcnt = 0;
	always #2.5 i_ref_clk = ~i_ref_clk;
	// Free-running millisecond stamp.
	always @(posedge i_ref_clk) tm <= tm + 1;
	arc_field_model i_arc_field_model (.i_ref_clk(i_ref_clk), .i_go(go),
		.i_blk(blk), .i_lit(lit), .o_start(cs), .o_block(bl), .o_light(lt));
	arc_trip_block i_arc_trip_block (.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n), .i_hsel(1'b1), .i_haddr(ha), .i_htrans(ht),
		.i_hwrite(w), .i_hsize(3'h2), .i_hwdata(hd), .i_hready(hr),
		.o_hreadyout(hr), .o_hresp(hp), .o_hrdata(hrd), .i_cycle_start(cs),
		.i_block(bl), .i_ph_pickup(misc[0]), .i_res_pickup(misc[1]),
		.i_light(lt), .i_press(misc[5:2]), .i_di(misc[6]),
		.i_sensor_fault(misc[10:7]), .i_io_fault(misc[11]),
		.i_prot_start(ps), .i_prot_trip(pt), .i_common_start_in(xs),
		.i_common_trip_in(xt), .i_force_enable(fen),
		.i_time_ms({16'h0000, tm}), .i_cur_a(misc[27:12]),
		.i_cur_b(misc[43:28]), .i_cur_c(misc[59:44]),
		.i_cur_res(misc[75:60]), .i_setting_group(misc[78:76]),
		.o_zone_trip_flag(zt), .o_zone_blocked_flag(zb),
		.o_sensor_status(ss), .o_common_start(st), .o_common_trip(tr),
		.o_common_cond(cond), .o_evt_valid(), .o_arc_evt_on(),
		.o_arc_evt_off(), .o_gen_evt_on(ge), .o_gen_evt_off(gf),
		.o_evt_time());
	task automatic complete_run;
	begin
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
	begin
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	// Waits for a rising edge with hready high; read data is taken there.
	task automatic wait_rdy;
		logic r;
	begin
		r = 1'b0;
		for (int k = 0; k < 50 && r !== 1'b1; k++)
		begin
			@(posedge i_ref_clk);
			r = hr;
			rdata = hrd;
		end
		if (r === 1'b1)
			chk("hresp", hp, 1'b0);
		if (r !== 1'b1)
		begin
			num_errors++;
			complete_run();
		end
	end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
	begin
		ha <= {24'h0, a};
		w <= wr;
		ht <= 2'h2;
		wait_rdy();
		ht <= 2'h0;
		hd <= d;
		wait_rdy();
	end
	endtask
	// One program cycle with fresh random measurements.
	task automatic evalc(input logic b, input logic [3:0] l);
	begin
		{blk, lit, go} <= {b, l, 1'b1};
		misc <= {$random(seed), $random(seed), $random(seed)};
		@(posedge i_ref_clk);
		go <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
	end
	endtask
	initial
	begin
		repeat (8) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		@(posedge i_ref_clk);
		bus(1, arc_prot_pkg::REG_ZONE_CFG0, 32'h0000_0009);
		evalc(0, 4'h1);
		chk("zone trip", zt, 1);
		chk("cond", cond, 3'h4);
		bus(0, arc_prot_pkg::REG_REC_CNT, 0);
		chk("records", rdata, 1);
		// Newest record holds this cycle's sensors, group and currents.
		ex = {13'h0, misc[78:76], 4'h0, misc[5:2] | 4'h1, 8'h00};
		bus(0, arc_prot_pkg::REG_REC_EVT, 0);
		chk("rec evt", rdata, ex);
		bus(0, arc_prot_pkg::REG_REC_IAB, 0);
		chk("rec currents", rdata, misc[43:12]);
		evalc(0, 4'h2);
		chk("unsourced", zt, 0);
		evalc(1, 4'h1);
		bus(0, arc_prot_pkg::REG_ARC_COND, 0);
		chk("blocked", rdata, 32'h0000_0010);
		chk("no trip", tr, 0);
		// Each of the three cycles so far changed a zone flag.
		bus(0, arc_prot_pkg::REG_ARC_CNT, 0);
		chk("arc count", rdata, 3);
		bus(1, arc_prot_pkg::REG_CTRL, 3);
		bus(0, arc_prot_pkg::REG_ARC_CNT, 0);
		chk("arc clear", rdata, 0);
		bus(0, 8'hfc, 0);
		chk("unmapped", rdata, 0);
		$display("zone test done");
		for (int i = 0; i < 40; i++)
		begin
			{ps, pt, xs, xt} <= 18'($random(seed));
			evalc(0, 4'h0);
			{ns, nt} = {|ps | xs, |pt | xt};
			chk("start", st, ns);
			chk("trip", tr, nt);
			ex = {28'h0, et & !nt, es & !ns, nt & !et, ns & !es};
			chk("gen evt", {gf, ge}, ex);
			ex = {14'h0, misc[11:2], 4'h0, misc[1], 1'b0, misc[0], 1'b0};
			chk("sensors", ss, ex);
			gcnt += ns & !es;
			gcnt += nt & !et;
			{es, et} = {ns, nt};
		end
		bus(0, arc_prot_pkg::REG_GEN_CNT, 0);
		chk("gen count", rdata, gcnt);
		$display("common test done");
		{ps, pt, xs, xt} <= 18'h0_0000;
		bus(1, arc_prot_pkg::REG_FORCE, 2);
		evalc(0, 4'h0);
		chk("unforced", cond, 3'h1);
		fen <= 1'b1;
		evalc(0, 4'h0);
		chk("force trip", cond, 3'h4);
		bus(1, arc_prot_pkg::REG_FORCE, 1);
		evalc(0, 4'h0);
		chk("force start", cond, 3'h2);
		$display("force test done");
		complete_run();
	end
endmodule

/* verilog/arc_fault_log.sv */
// Ring store of the most recent arc operation records.
module arc_fault_log
#(
	parameter int DEPTH = arc_prot_pkg::REC_DEPTH
)
(
	input  wire logic                                 i_ref_clk,
	input  wire logic                                 i_reset_n,
	input  wire logic                                 i_wr,
	input  wire arc_prot_pkg::rec_t                   i_rec,
	input  wire logic [arc_prot_pkg::REC_IDX_W-1:0]   i_sel,
	output arc_prot_pkg::rec_t                        o_rec,
	output logic      [arc_prot_pkg::REC_IDX_W-1:0]   o_count
);

	localparam int IW = arc_prot_pkg::REC_IDX_W;
	localparam logic [IW:0] DEPTH_W = (IW+1)'(DEPTH);

	typedef struct packed {
		arc_prot_pkg::rec_t [DEPTH-1:0] mem;
		logic [IW-1:0]                  wptr;
		logic [IW-1:0]                  count;
	} log_t;

	log_t st_ff;
	log_t nxt_st;
	logic [IW:0] idx;

	// A write lands on the oldest slot once the ring is full.
	always_comb
	begin
		nxt_st = st_ff;
		if (i_wr)
		begin
			nxt_st.mem[st_ff.wptr] = i_rec;
			if (st_ff.wptr == IW'(DEPTH - 1))
				nxt_st.wptr = '0;
			else
				nxt_st.wptr = st_ff.wptr + 1'b1;
			if (st_ff.count != IW'(DEPTH))
				nxt_st.count = st_ff.count + 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// Selector zero is the newest record; unused slots read as zero.
	always_comb
	begin
		idx = {1'b0, st_ff.wptr} + DEPTH_W - 1'b1 - {1'b0, i_sel};
		if (idx >= DEPTH_W)
			idx = idx - DEPTH_W;
		if (i_sel < st_ff.count)
			o_rec = st_ff.mem[idx[IW-1:0]];
		else
			o_rec = '0;
	end

	assign o_count = st_ff.count;

endmodule

/* verilog/arc_trip_block.sv */
// Arc trip/block decision, event logging and common start/trip signals.
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module arc_trip_block
#(
	parameter int NPROT = 8
)
(
	input  wire logic                              i_ref_clk,
	input  wire logic                              i_reset_n,
	input  wire logic                              i_hsel,
	input  wire logic [31:0]                       i_haddr,
	input  wire logic [1:0]                        i_htrans,
	input  wire logic                              i_hwrite,
	input  wire logic [2:0]                        i_hsize,
	input  wire logic [31:0]                       i_hwdata,
	input  wire logic                              i_hready,
	output logic                                   o_hreadyout,
	output logic                                   o_hresp,
	output logic      [31:0]                       o_hrdata,
	input  wire logic                              i_cycle_start,
	input  wire logic                              i_block,
	input  wire logic                              i_ph_pickup,
	input  wire logic                              i_res_pickup,
	input  wire logic [arc_prot_pkg::NCH-1:0]      i_light,
	input  wire logic [arc_prot_pkg::NCH-1:0]      i_press,
	input  wire logic                              i_di,
	input  wire logic [arc_prot_pkg::NCH-1:0]      i_sensor_fault,
	input  wire logic                              i_io_fault,
	input  wire logic [NPROT-1:0]                  i_prot_start,
	input  wire logic [NPROT-1:0]                  i_prot_trip,
	input  wire logic                              i_common_start_in,
	input  wire logic                              i_common_trip_in,
	input  wire logic                              i_force_enable,
	input  wire logic [arc_prot_pkg::TS_W-1:0]     i_time_ms,
	input  wire logic [arc_prot_pkg::CUR_W-1:0]    i_cur_a,
	input  wire logic [arc_prot_pkg::CUR_W-1:0]    i_cur_b,
	input  wire logic [arc_prot_pkg::CUR_W-1:0]    i_cur_c,
	input  wire logic [arc_prot_pkg::CUR_W-1:0]    i_cur_res,
	input  wire logic [arc_prot_pkg::GRP_W-1:0]    i_setting_group,
	output logic      [arc_prot_pkg::NZONE-1:0]    o_zone_trip_flag,
	output logic      [arc_prot_pkg::NZONE-1:0]    o_zone_blocked_flag,
	output logic      [arc_prot_pkg::SENSOR_W-1:0] o_sensor_status,
	output logic                                   o_common_start,
	output logic                                   o_common_trip,
	output logic      [2:0]                        o_common_cond,
	output logic                                   o_evt_valid,
	output logic      [arc_prot_pkg::NFLAG-1:0]    o_arc_evt_on,
	output logic      [arc_prot_pkg::NFLAG-1:0]    o_arc_evt_off,
	output logic      [1:0]                        o_gen_evt_on,
	output logic      [1:0]                        o_gen_evt_off,
	output logic      [arc_prot_pkg::TS_W-1:0]     o_evt_time
);

	localparam int NZ = arc_prot_pkg::NZONE;
	localparam int NC = arc_prot_pkg::NCH;
	localparam int NF = arc_prot_pkg::NFLAG;
	localparam int AW = arc_prot_pkg::ADDR_W;
	localparam int CW = arc_prot_pkg::CNT_W;
	localparam int ZW = arc_prot_pkg::ZC_W;
	localparam int IW = arc_prot_pkg::REC_IDX_W;

	typedef struct packed {
		logic                               rd_wait;
		logic                               wr_pend;
		logic [AW-1:0]                      addr;
		logic [31:0]                        rdata;
		logic [1:0]                         force_sel;
		logic [NZ-1:0][ZW-1:0]              zcfg;
		logic [NF-1:0]                      on_sel;
		logic [NF-1:0]                      off_sel;
		logic [3:0]                         gen_sel;
		logic [IW-1:0]                      rec_sel;
		logic                               eval;
		logic                               blk;
		logic                               ph;
		logic                               res;
		logic [NC-1:0]                      light;
		logic [NC-1:0]                      press;
		logic                               di;
		logic [NC-1:0]                      sflt;
		logic                               iof;
		logic                               any_st;
		logic                               any_tr;
		logic                               force_en;
		logic [arc_prot_pkg::TS_W-1:0]      ts;
		logic [arc_prot_pkg::CUR_W-1:0]     ia;
		logic [arc_prot_pkg::CUR_W-1:0]     ib;
		logic [arc_prot_pkg::CUR_W-1:0]     ic;
		logic [arc_prot_pkg::CUR_W-1:0]     i0;
		logic [arc_prot_pkg::GRP_W-1:0]     grp;
		logic [NZ-1:0]                      pick;
		logic [NF-1:0]                      flags;
		logic                               gstart;
		logic                               gtrip;
		logic [2:0]                         cond;
		logic [CW-1:0]                      arc_cnt;
		logic [CW-1:0]                      gen_cnt;
		logic                               evt_valid;
		logic [NF-1:0]                      evt_on;
		logic [NF-1:0]                      evt_off;
		logic [1:0]                         gevt_on;
		logic [1:0]                         gevt_off;
		logic [arc_prot_pkg::TS_W-1:0]      evt_ts;
	} st_t;

	st_t                 st_ff;
	st_t                 nxt_st;
	logic                rec_wr;
	arc_prot_pkg::rec_t  rec_in;
	arc_prot_pkg::rec_t  rec_rd;
	logic [IW-1:0]       rec_count;

	// Clear first, then add, so an event in the clear cycle still counts.
	function automatic logic [CW-1:0] cnt_next(input logic [CW-1:0] c,
		input logic clr, input logic [1:0] inc);
		logic [CW-1:0] base;
		base = clr ? '0 : c;
		return base + CW'(inc);
	endfunction

	// Register read decode; unmapped offsets read as zero.
	function automatic logic [31:0] rd_word(input st_t s,
		input arc_prot_pkg::rec_t r, input logic [IW-1:0] cnt);
		logic [31:0] w;
		w = '0;
		case (s.addr)
			arc_prot_pkg::REG_FORCE:    w[1:0] = s.force_sel;
			arc_prot_pkg::REG_ON_SEL:   w[NF-1:0] = s.on_sel;
			arc_prot_pkg::REG_OFF_SEL:  w[NF-1:0] = s.off_sel;
			arc_prot_pkg::REG_GEN_SEL:  w[3:0] = s.gen_sel;
			arc_prot_pkg::REG_ARC_COND: w[2*NZ-1:0] = s.flags[2*NZ-1:0];
			arc_prot_pkg::REG_SENSOR:
				w[arc_prot_pkg::SENSOR_W-1:0] =
					s.flags[NF-1:arc_prot_pkg::F_SENSOR];
			arc_prot_pkg::REG_GEN_COND: w[2:0] = s.cond;
			arc_prot_pkg::REG_ARC_CNT:  w[CW-1:0] = s.arc_cnt;
			arc_prot_pkg::REG_GEN_CNT:  w[CW-1:0] = s.gen_cnt;
			arc_prot_pkg::REG_REC_SEL:  w[IW-1:0] = s.rec_sel;
			arc_prot_pkg::REG_REC_CNT:  w[IW-1:0] = cnt;
			arc_prot_pkg::REG_REC_TLO:  w = r.ts[arc_prot_pkg::TLO_W-1:0];
			arc_prot_pkg::REG_REC_THI:
				w[arc_prot_pkg::TS_W-arc_prot_pkg::TLO_W-1:0] =
					r.ts[arc_prot_pkg::TS_W-1:arc_prot_pkg::TLO_W];
			arc_prot_pkg::REG_REC_EVT:
			begin
				w[arc_prot_pkg::RE_EVT +: arc_prot_pkg::EVT_W] = r.evt;
				w[arc_prot_pkg::RE_SENS +: NC] = r.sens;
				w[arc_prot_pkg::RE_GRP +: arc_prot_pkg::GRP_W] = r.grp;
			end
			arc_prot_pkg::REG_REC_IAB:  w = {r.ib, r.ia};
			arc_prot_pkg::REG_REC_IC0:  w = {r.i0, r.ic};
			default:
			begin
				for (int z = 0; z < NZ; z++)
					if (s.addr == arc_prot_pkg::REG_ZONE_CFG0
						+ AW'(z * arc_prot_pkg::ZONE_STRIDE))
						w[ZW-1:0] = s.zcfg[z];
			end
		endcase
		return w;
	endfunction

	// Whole next state: bus slave, input sampling, decisions and events.
	always_comb
	begin
		logic          arc_clr;
		logic          gen_clr;
		logic [NZ-1:0] pk;
		logic [NF-1:0] nf;
		logic [NF-1:0] chg;
		logic [NZ-1:0] trip_rise;
		logic [ZW-1:0] cfg;
		logic          dterm;
		logic          anych;
		logic          gs;
		logic          gt;
		arc_clr = 1'b0;
		gen_clr = 1'b0;
		pk = '0;
		nf = st_ff.flags;
		chg = '0;
		trip_rise = '0;
		cfg = '0;
		dterm = 1'b0;
		anych = 1'b0;
		gs = 1'b0;
		gt = 1'b0;
		nxt_st = st_ff;
		rec_wr = 1'b0;
		rec_in = '0;
		nxt_st.eval = i_cycle_start;
		nxt_st.evt_valid = 1'b0;

		// Bus: reads take one wait state, writes land in the data phase.
		nxt_st.rd_wait = 1'b0;
		nxt_st.wr_pend = 1'b0;
		if (st_ff.rd_wait)
			nxt_st.rdata = rd_word(st_ff, rec_rd, rec_count);
		if (st_ff.wr_pend)
		begin
			case (st_ff.addr)
				arc_prot_pkg::REG_CTRL:
				begin
					arc_clr = i_hwdata[arc_prot_pkg::CTL_ARC_CLR];
					gen_clr = i_hwdata[arc_prot_pkg::CTL_GEN_CLR];
				end
				arc_prot_pkg::REG_FORCE:   nxt_st.force_sel = i_hwdata[1:0];
				arc_prot_pkg::REG_ON_SEL:  nxt_st.on_sel = i_hwdata[NF-1:0];
				arc_prot_pkg::REG_OFF_SEL: nxt_st.off_sel = i_hwdata[NF-1:0];
				arc_prot_pkg::REG_GEN_SEL: nxt_st.gen_sel = i_hwdata[3:0];
				arc_prot_pkg::REG_REC_SEL: nxt_st.rec_sel = i_hwdata[IW-1:0];
				default:
				begin
					for (int z = 0; z < NZ; z++)
						if (st_ff.addr == arc_prot_pkg::REG_ZONE_CFG0
							+ AW'(z * arc_prot_pkg::ZONE_STRIDE))
							nxt_st.zcfg[z] = i_hwdata[ZW-1:0];
				end
			endcase
		end
		if (i_hsel && i_htrans[1] && i_hready)
		begin
			nxt_st.addr = i_haddr[AW-1:0];
			nxt_st.rd_wait = !i_hwrite;
			nxt_st.wr_pend = i_hwrite;
		end

		if (i_cycle_start)
		begin
			nxt_st.blk = i_block;
			nxt_st.ph = i_ph_pickup;
			nxt_st.res = i_res_pickup;
			nxt_st.light = i_light;
			nxt_st.press = i_press;
			nxt_st.di = i_di;
			nxt_st.sflt = i_sensor_fault;
			nxt_st.iof = i_io_fault;
			nxt_st.any_st = (|i_prot_start) | i_common_start_in;
			nxt_st.any_tr = (|i_prot_trip) | i_common_trip_in;
			nxt_st.force_en = i_force_enable;
			nxt_st.ts = i_time_ms;
			nxt_st.ia = i_cur_a;
			nxt_st.ib = i_cur_b;
			nxt_st.ic = i_cur_c;
			nxt_st.i0 = i_cur_res;
			nxt_st.grp = i_setting_group;
		end

		// decisions only on the evaluation cycle
		if (st_ff.eval)
		begin
			for (int z = 0; z < NZ; z++)
			begin
				cfg = st_ff.zcfg[z];
				case (cfg[arc_prot_pkg::ZC_DI +: 2])
					arc_prot_pkg::DI_LIGHT_IN: dterm = st_ff.di;
					arc_prot_pkg::DI_CURR_IN:
						dterm = st_ff.di & (|st_ff.light | |st_ff.press);
					default: dterm = 1'b0;
				endcase
				pk[z] = cfg[arc_prot_pkg::ZC_EN] & (
					(st_ff.ph & cfg[arc_prot_pkg::ZC_PH]) |
					(st_ff.res & cfg[arc_prot_pkg::ZC_RES]) |
					|(st_ff.light & cfg[arc_prot_pkg::ZC_LIGHT +: NC]) |
					|(st_ff.press & cfg[arc_prot_pkg::ZC_PRESS +: NC]) |
					dterm);
				if (pk[z] && !st_ff.pick[z])
				begin
					if (st_ff.blk)
						nf[arc_prot_pkg::F_BLK + z] = 1'b1;
					else
						nf[arc_prot_pkg::F_TRIP + z] = 1'b1;
				end
				else if (!pk[z])
				begin
					nf[arc_prot_pkg::F_BLK + z] = 1'b0;
					nf[arc_prot_pkg::F_TRIP + z] = 1'b0;
				end
			end
			nf[arc_prot_pkg::F_PHBLK] = st_ff.ph & st_ff.blk;
			nf[arc_prot_pkg::F_PHST] = st_ff.ph & !st_ff.blk;
			nf[arc_prot_pkg::F_RESBLK] = st_ff.res & st_ff.blk;
			nf[arc_prot_pkg::F_RESST] = st_ff.res & !st_ff.blk;
			nf[arc_prot_pkg::F_LIGHT +: NC] = st_ff.light;
			nf[arc_prot_pkg::F_PRESS +: NC] = st_ff.press;
			nf[arc_prot_pkg::F_DI] = st_ff.di;
			nf[arc_prot_pkg::F_SFLT +: NC] = st_ff.sflt;
			nf[arc_prot_pkg::F_IOFLT] = st_ff.iof;
			nxt_st.pick = pk;
			nxt_st.flags = nf;

			// blocking masks only the zone pick-ups feeding common start
			gs = st_ff.any_st | |(pk & ~{NZ{st_ff.blk}});
			gt = st_ff.any_tr | |nf[arc_prot_pkg::F_TRIP +: NZ];
			if (st_ff.force_en)
			begin
				if (st_ff.force_sel == arc_prot_pkg::FORCE_START)
				begin
					gs = 1'b1;
					gt = 1'b0;
				end
				else if (st_ff.force_sel == arc_prot_pkg::FORCE_TRIP)
				begin
					gs = 1'b1;
					gt = 1'b1;
				end
			end
			nxt_st.gstart = gs;
			nxt_st.gtrip = gt;
			if (gt)
				nxt_st.cond = arc_prot_pkg::COND_TRIP;
			else if (gs)
				nxt_st.cond = arc_prot_pkg::COND_START;
			else
				nxt_st.cond = arc_prot_pkg::COND_NORMAL;

			chg = nf ^ st_ff.flags;
			anych = |chg;
			nxt_st.evt_on = chg & nf & st_ff.on_sel;
			nxt_st.evt_off = chg & st_ff.flags & st_ff.off_sel;
			nxt_st.gevt_on = {gt & !st_ff.gtrip, gs & !st_ff.gstart}
				& st_ff.gen_sel[arc_prot_pkg::GS_ON +: 2];
			nxt_st.gevt_off = {!gt & st_ff.gtrip, !gs & st_ff.gstart}
				& st_ff.gen_sel[arc_prot_pkg::GS_OFF +: 2];
			nxt_st.evt_valid = |{nxt_st.evt_on, nxt_st.evt_off,
				nxt_st.gevt_on, nxt_st.gevt_off};
			nxt_st.evt_ts = st_ff.ts;

			// one record per cycle with a new zone trip, lowest such zone as event
			trip_rise = nf[arc_prot_pkg::F_TRIP +: NZ]
				& ~st_ff.flags[arc_prot_pkg::F_TRIP +: NZ];
			rec_wr = |trip_rise;
			for (int z = NZ - 1; z >= 0; z--)
				if (trip_rise[z])
					rec_in.evt = arc_prot_pkg::EVT_W'(arc_prot_pkg::F_TRIP + z);
			rec_in.ts = st_ff.ts;
			rec_in.ia = st_ff.ia;
			rec_in.ib = st_ff.ib;
			rec_in.ic = st_ff.ic;
			rec_in.i0 = st_ff.i0;
			rec_in.sens = st_ff.light | st_ff.press;
			rec_in.grp = st_ff.grp;
			nxt_st.gen_cnt = cnt_next(st_ff.gen_cnt, gen_clr,
				2'(nxt_st.gstart & !st_ff.gstart) +
				2'(nxt_st.gtrip & !st_ff.gtrip));
		end
		else
			nxt_st.gen_cnt = cnt_next(st_ff.gen_cnt, gen_clr, 2'b00);
		nxt_st.arc_cnt = cnt_next(st_ff.arc_cnt, arc_clr, {1'b0, anych});
	end

	// State register with documented reset values.
	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			st_ff <= '0;
			st_ff.on_sel <= arc_prot_pkg::SEL_RST;
			st_ff.off_sel <= arc_prot_pkg::SEL_RST;
			st_ff.gen_sel <= arc_prot_pkg::GEN_SEL_RST;
			st_ff.cond <= arc_prot_pkg::COND_NORMAL;
			st_ff.force_sel <= arc_prot_pkg::FORCE_NORMAL;
		end
		else
			st_ff <= nxt_st;
	end

	arc_fault_log u_log
	(
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_wr      (rec_wr),
		.i_rec     (rec_in),
		.i_sel     (st_ff.rec_sel),
		.o_rec     (rec_rd),
		.o_count   (rec_count)
	);

	// Outputs straight from the state register, except hresp tied to zero.
	assign o_hreadyout = !st_ff.rd_wait;
	assign o_hresp = 1'b0;
	assign o_hrdata = st_ff.rdata;
	assign o_zone_trip_flag = st_ff.flags[arc_prot_pkg::F_TRIP +: NZ];
	assign o_zone_blocked_flag = st_ff.flags[arc_prot_pkg::F_BLK +: NZ];
	assign o_sensor_status = st_ff.flags[NF-1:arc_prot_pkg::F_SENSOR];
	assign o_common_start = st_ff.gstart;
	assign o_common_trip = st_ff.gtrip;
	assign o_common_cond = st_ff.cond;
	assign o_evt_valid = st_ff.evt_valid;
	assign o_arc_evt_on = st_ff.evt_on;
	assign o_arc_evt_off = st_ff.evt_off;
	assign o_gen_evt_on = st_ff.gevt_on;
	assign o_gen_evt_off = st_ff.gevt_off;
	assign o_evt_time = st_ff.evt_ts;

endmodule
